// File: hdl/sdio_top.sv
// Top of the strobed digital I/O block with APB registers
`timescale 1ns/10ps
// What this block does
// - Four eight-line ports written and read directly by software.
// - Each line individually set as input or output.
// - Unstrobed use turns request/stop into inputs, ack/clock into outputs.
// - Two independent group controllers run strobed transfers concurrently.
// - Ports assigned to groups set width; unassigned ports stay unstrobed.
// - Each group has its own ack, request, clock and stop lines.
// - Internal request pulses paced by a 32-bit period counter per group.
// - Start and stop triggers with selectable rising or falling edge.
// - Triggers honoured only in pattern-generation and change-detection operation.
// - Change detection requests only when input data changes.
// - Both sides strobe each other and may withhold strobes.
// - Pattern detector can issue start or stop trigger.
// - Detector uses mask, pattern and match-or-mismatch polarity.
// - Immediate detection compares live input continuously.
// - Strobed detection compares only request-latched data.
// - Immediate matches of 20 ns or less rejected, 60 ns held detected.
// - Strobed detection starts only with an external request source.
// - Change detection watches masked bits, captures all bits.
module sdio_top (
  input  wire logic        clk,
  input  wire logic        resetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [31:0] io_in,
  output logic [31:0]      io_out,
  output logic [31:0]      io_oe,
  input  wire logic [1:0]  req_line,
  input  wire logic [1:0]  stop_trigger_line,
  output logic [1:0]       start_trigger_line,
  output logic [1:0]       pclk_line
);
  import sdio_pkg::*;
  // ----------------------------------------------------------------
  // Registers and synchronisers
  // ----------------------------------------------------------------
  logic [31:0] port_out;
  logic [31:0] port_dir;
  logic [3:0]  misc_out;
  logic [31:0] ctrl     [2];
  logic [31:0] period   [2];
  logic [31:0] mask     [2];
  logic [31:0] pattern  [2];
  logic [31:0] dout     [2];
  logic [1:0]  go;
  logic [31:0] in_s1;
  logic [31:0] in_s2;
  logic [1:0]  req_s1;
  logic [1:0]  req_s2;
  logic [1:0]  stop_s1;
  logic [1:0]  stop_s2;
  logic        wr;
  logic        rd;
  logic        gsel;
  logic        gidx;
  logic [7:0]  goff;
  logic        hit;
  logic [31:0] rdata;
  logic [31:0] grp_drive [2];
  logic [31:0] grp_dout  [2];
  logic [31:0] next_io_out;
  logic [31:0] next_io_oe;
  sdio_grp_if gi0 ();
  sdio_grp_if gi1 ();
  function automatic logic [31:0] owned_lines(input logic [31:0] c);
    owned_lines = {{8{c[CTRL_PORTS_LO+3]}}, {8{c[CTRL_PORTS_LO+2]}},
                   {8{c[CTRL_PORTS_LO+1]}}, {8{c[CTRL_PORTS_LO]}}};
  endfunction
  // Pins come from outside the clock domain
  always_ff @(posedge clk) begin
    if (!resetn) begin
      in_s1   <= 32'h0000_0000;
      in_s2   <= 32'h0000_0000;
      req_s1  <= 2'h0;
      req_s2  <= 2'h0;
      stop_s1 <= 2'h0;
      stop_s2 <= 2'h0;
    end else begin
      in_s1   <= io_in;
      in_s2   <= in_s1;
      req_s1  <= req_line;
      req_s2  <= req_s1;
      stop_s1 <= stop_trigger_line;
      stop_s2 <= stop_s1;
    end
  end
  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------
  assign wr   = psel && penable && pwrite;
  assign rd   = psel && !pwrite;
  assign gsel = (paddr >= OFF_G_BASE) && (paddr < OFF_G_BASE + 8'(2 * G_STRIDE));
  assign gidx = (paddr >= OFF_G_BASE + G_STRIDE);
  assign goff = paddr - (gidx ? OFF_G_BASE + G_STRIDE : OFF_G_BASE);
  always_comb begin
    hit   = 1'b1;
    rdata = 32'h0000_0000;
    if (gsel) begin
      unique case (goff)
        OFF_G_CTRL:     rdata = ctrl[gidx] & 32'h7FFF_FFFF;
        OFF_G_PERIOD:   rdata = period[gidx];
        OFF_G_MASK:     rdata = mask[gidx];
        OFF_G_PATTERN:  rdata = pattern[gidx];
        OFF_G_DATA_OUT: rdata = dout[gidx];
        OFF_G_DATA_IN:  rdata = gidx ? gi1.data_in : gi0.data_in;
        OFF_G_STATUS:   rdata = {24'h000000, gidx ? gi1.status : gi0.status};
        default:        hit   = 1'b0;
      endcase
    end else begin
      unique case (paddr)
        OFF_PORT_OUT: rdata = port_out;
        OFF_PORT_DIR: rdata = port_dir;
        OFF_PORT_IN:  rdata = in_s2;
        OFF_MISC:     rdata = {26'h0, stop_s2, req_s2, 2'h0} | {28'h0, misc_out};
        default:      hit   = 1'b0;
      endcase
    end
  end
  // Zero-wait slave: answer in the access cycle
  always_ff @(posedge clk) begin
    if (!resetn) begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel && !penable;
      pslverr <= psel && !penable && !hit;
      if (rd && !penable) begin
        prdata <= rdata;
      end
    end
  end
  // Register writes
  always_ff @(posedge clk) begin
    if (!resetn) begin
      port_out <= 32'h0000_0000;
      port_dir <= 32'h0000_0000;
      misc_out <= 4'h0;
      go       <= 2'h0;
      for (int i = 0; i < 2; i++) begin
        ctrl[i]    <= CTRL_RESET;
        period[i]  <= PERIOD_RESET;
        mask[i]    <= 32'h0000_0000;
        pattern[i] <= 32'h0000_0000;
        dout[i]    <= 32'h0000_0000;
      end
    end else begin
      go <= 2'h0;
      if (wr && pready && hit) begin
        if (gsel) begin
          unique case (goff)
            OFF_G_CTRL: begin
              ctrl[gidx] <= pwdata & 32'h7FFF_FFFF;
              go[gidx]   <= pwdata[CTRL_GO];
            end
            OFF_G_PERIOD:   period[gidx]  <= pwdata;
            OFF_G_MASK:     mask[gidx]    <= pwdata;
            OFF_G_PATTERN:  pattern[gidx] <= pwdata;
            OFF_G_DATA_OUT: dout[gidx]    <= pwdata;
            default:        ;
          endcase
        end else begin
          unique case (paddr)
            OFF_PORT_OUT: port_out <= pwdata;
            OFF_PORT_DIR: port_dir <= pwdata;
            OFF_MISC:     misc_out <= pwdata[3:0];
            default:      ;
          endcase
        end
      end
    end
  end
  // ----------------------------------------------------------------
  // Groups
  // ----------------------------------------------------------------
  assign gi0.ctrl     = ctrl[0];
  assign gi0.period   = period[0];
  assign gi0.mask     = mask[0];
  assign gi0.pattern  = pattern[0];
  assign gi0.data_out = dout[0];
  assign gi0.go       = go[0];
  assign gi0.pins_in  = in_s2;
  assign gi0.req_in   = req_s2[0];
  assign gi0.stop_in  = stop_s2[0];
  assign gi1.ctrl     = ctrl[1];
  assign gi1.period   = period[1];
  assign gi1.mask     = mask[1];
  assign gi1.pattern  = pattern[1];
  assign gi1.data_out = dout[1];
  assign gi1.go       = go[1];
  assign gi1.pins_in  = in_s2;
  assign gi1.req_in   = req_s2[1];
  assign gi1.stop_in  = stop_s2[1];
  sdio_group u_g0 (.clk(clk), .resetn(resetn), .g(gi0));
  sdio_group u_g1 (.clk(clk), .resetn(resetn), .g(gi1));
  assign grp_drive[0] = gi0.drive;
  assign grp_drive[1] = gi1.drive & ~owned_lines(ctrl[0]);
  assign grp_dout[0]  = dout[0];
  assign grp_dout[1]  = dout[1];
  // Group 0 wins a port claimed by both, so a line never has two drivers
  always_comb begin
    next_io_oe  = port_dir & ~owned_lines(ctrl[0]) & ~owned_lines(ctrl[1]);
    next_io_out = port_out;
    for (int i = 0; i < 2; i++) begin
      next_io_oe  = next_io_oe | grp_drive[i];
      next_io_out = (next_io_out & ~grp_drive[i]) | (grp_dout[i] & grp_drive[i]);
    end
  end
  always_ff @(posedge clk) begin
    if (!resetn) begin
      io_out             <= 32'h0000_0000;
      io_oe              <= 32'h0000_0000;
      start_trigger_line <= 2'h0;
      pclk_line          <= 2'h0;
    end else begin
      io_out <= next_io_out;
      io_oe  <= next_io_oe;
      start_trigger_line[0] <= ctrl[0][CTRL_ENABLE] ? gi0.ack_out : misc_out[0];
      start_trigger_line[1] <= ctrl[1][CTRL_ENABLE] ? gi1.ack_out : misc_out[1];
      pclk_line[0] <= ctrl[0][CTRL_ENABLE] ? gi0.pclk_out : misc_out[2];
      pclk_line[1] <= ctrl[1][CTRL_ENABLE] ? gi1.pclk_out : misc_out[3];
    end
  end
endmodule // sdio_top

// File: hdl/sdio_pkg.sv
// Package of constants for the strobed digital I/O block
package sdio_pkg;
  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFF_PORT_OUT   = 8'h00;
  localparam logic [7:0] OFF_PORT_DIR   = 8'h04;
  localparam logic [7:0] OFF_PORT_IN    = 8'h08;
  localparam logic [7:0] OFF_MISC       = 8'h0C;
  localparam logic [7:0] OFF_G_BASE     = 8'h10;
  localparam logic [7:0] G_STRIDE       = 8'h20;
  localparam logic [7:0] OFF_G_CTRL     = 8'h00;
  localparam logic [7:0] OFF_G_PERIOD   = 8'h04;
  localparam logic [7:0] OFF_G_MASK     = 8'h08;
  localparam logic [7:0] OFF_G_PATTERN  = 8'h0C;
  localparam logic [7:0] OFF_G_DATA_OUT = 8'h10;
  localparam logic [7:0] OFF_G_DATA_IN  = 8'h14;
  localparam logic [7:0] OFF_G_STATUS   = 8'h18;
  // ----------------------------------------------------------------
  // Group control fields
  // ----------------------------------------------------------------
  localparam int CTRL_ENABLE    = 0;
  localparam int CTRL_MODE_LO   = 1;  // 2 bits: mode
  localparam int CTRL_EXT_REQ   = 3;
  localparam int CTRL_DIR_OUT   = 4;
  localparam int CTRL_USE_START = 5;
  localparam int CTRL_USE_STOP  = 6;
  localparam int CTRL_START_RISE = 7;
  localparam int CTRL_STOP_RISE = 8;
  localparam int CTRL_PD_START  = 9;
  localparam int CTRL_PD_STOP   = 10;
  localparam int CTRL_PD_STROBED = 11;
  localparam int CTRL_PD_MISMATCH = 12;
  localparam int CTRL_PORTS_LO  = 16; // 4 bits: ports owned
  localparam int CTRL_GO        = 31; // write 1: arm
  localparam logic [31:0] CTRL_RESET   = 32'h0000_0000;
  localparam logic [31:0] PERIOD_RESET = 32'h0000_0010;
  // ----------------------------------------------------------------
  // Modes and timing
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    SDIO_MODE_PATTERN   = 2'b00,
    SDIO_MODE_CHANGE    = 2'b01,
    SDIO_MODE_HANDSHAKE = 2'b10,
    SDIO_MODE_BURST     = 2'b11
  } sdio_mode_t;
  localparam int CLK_PERIOD_PS  = 8000;
  localparam int GLITCH_MAX_PS  = 20000;
  localparam int MATCH_MIN_PS   = 60000;
  // Longest time rounds down: filter must accept by 60 ns, so count <= 60/8
  localparam int MATCH_CYCLES   = MATCH_MIN_PS / CLK_PERIOD_PS - 2;
  localparam int GLITCH_CYCLES  = (GLITCH_MAX_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam logic [3:0] FILT_COUNT = 4'(MATCH_CYCLES);
endpackage

// File: hdl/sdio_grp_if.sv
// Interface between top and a group controller
`timescale 1ns/10ps
interface sdio_grp_if;
  logic [31:0] ctrl;
  logic [31:0] period;
  logic [31:0] mask;
  logic [31:0] pattern;
  logic [31:0] data_out;
  logic        go;
  logic [31:0] pins_in;
  logic        req_in;
  logic        stop_in;
  logic        ack_out;
  logic        pclk_out;
  logic [31:0] data_in;
  logic [31:0] drive;
  logic [7:0]  status;
  modport ctl (input ctrl, period, mask, pattern, data_out, go, pins_in, req_in, stop_in,
               output ack_out, pclk_out, data_in, drive, status);
  modport top (output ctrl, period, mask, pattern, data_out, go, pins_in, req_in, stop_in,
               input ack_out, pclk_out, data_in, drive, status);
endinterface

// File: hdl/sdio_group.sv
// One strobed group controller
`timescale 1ns/10ps
module sdio_group (
  input  wire logic clk,
  input  wire logic resetn,
  sdio_grp_if.ctl   g
);
  import sdio_pkg::*;
  typedef enum logic [1:0] {
    SDIO_ST_IDLE  = 2'b00,
    SDIO_ST_ARMED = 2'b01,
    SDIO_ST_RUN   = 2'b10
  } sdio_st_t;
  sdio_st_t    st;
  logic [31:0] cnt;
  logic        req_d;
  logic        stop_d;
  logic        ack_d;
  logic [3:0]  filt;
  logic        imm_hit;
  logic [31:0] last_in;
  logic        strobe_hit;
  logic        req_pulse;
  logic        int_pulse;
  logic        start_ev;
  logic        stop_ev;
  logic        fire;
  logic [31:0] owned;
  logic [1:0]  mode;
  logic        ext_req;
  logic        pat_mode;
  function automatic logic pat_match(input logic [31:0] d, input logic [31:0] m,
                                     input logic [31:0] p, input logic mis);
    pat_match = (((d ^ p) & m) == 32'h0000_0000) ^ mis;
  endfunction
  function automatic logic edge_of(input logic now, input logic was, input logic rise);
    edge_of = rise ? (now & ~was) : (~now & was);
  endfunction
  assign mode     = g.ctrl[CTRL_MODE_LO +: 2];
  assign ext_req  = g.ctrl[CTRL_EXT_REQ];
  assign pat_mode = (mode == SDIO_MODE_PATTERN) || (mode == SDIO_MODE_CHANGE);
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      owned[i*8 +: 8] = {8{g.ctrl[CTRL_PORTS_LO + i]}};
    end
  end
  // ----------------------------------------------------------------
  // Edge history
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!resetn) begin
      req_d  <= 1'b0;
      stop_d <= 1'b0;
    end else begin
      req_d  <= g.req_in;
      stop_d <= g.stop_in;
    end
  end
  // Internal pacer: one request pulse per period
  always_ff @(posedge clk) begin
    if (!resetn || st != SDIO_ST_RUN) begin
      cnt <= 32'h0000_0000;
    end else if (cnt >= g.period - 32'h0000_0001) begin
      cnt <= 32'h0000_0000;
    end else begin
      cnt <= cnt + 32'h0000_0001;
    end
  end
  assign int_pulse = (st == SDIO_ST_RUN) && (cnt >= g.period - 32'h0000_0001);
  always_comb begin
    unique case (mode)
      SDIO_MODE_PATTERN:   req_pulse = ext_req ? (g.req_in & ~req_d) : int_pulse;
      SDIO_MODE_CHANGE:    req_pulse = ((g.pins_in ^ last_in) & g.mask & owned)
                                       != 32'h0000_0000;
      SDIO_MODE_HANDSHAKE: req_pulse = g.req_in & ~req_d & ack_d;
      SDIO_MODE_BURST:     req_pulse = g.req_in & ack_d;
    endcase
  end
  // ----------------------------------------------------------------
  // Pattern detection
  // ----------------------------------------------------------------
  // Short matches are rejected so line-switching transients never trigger immediate detection
  always_ff @(posedge clk) begin
    if (!resetn) begin
      filt <= 4'h0;
    end else if (!pat_match(g.pins_in, g.mask & owned, g.pattern,
                            g.ctrl[CTRL_PD_MISMATCH])) begin
      filt <= 4'h0;
    end else if (filt != FILT_COUNT) begin
      filt <= filt + 4'h1;
    end
  end
  assign imm_hit    = (filt == FILT_COUNT - 4'h1);
  assign strobe_hit = req_pulse && pat_match(g.pins_in, g.mask & owned, g.pattern,
                                             g.ctrl[CTRL_PD_MISMATCH]);
  assign fire = g.ctrl[CTRL_PD_STROBED] ? strobe_hit : imm_hit;
  always_comb begin
    start_ev = 1'b0;
    stop_ev  = 1'b0;
    if (pat_mode) begin
      if (g.ctrl[CTRL_PD_START]) begin
        start_ev = fire && (!g.ctrl[CTRL_PD_STROBED] || ext_req);
      end else begin
        start_ev = edge_of(g.req_in, req_d, g.ctrl[CTRL_START_RISE]);
      end
      if (g.ctrl[CTRL_PD_STOP]) begin
        stop_ev = fire;
      end else if (g.ctrl[CTRL_USE_STOP]) begin
        stop_ev = edge_of(g.stop_in, stop_d, g.ctrl[CTRL_STOP_RISE]);
      end
    end
  end
  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!resetn || !g.ctrl[CTRL_ENABLE]) begin
      st <= SDIO_ST_IDLE;
    end else begin
      unique case (st)
        SDIO_ST_IDLE:  if (g.go) st <= (pat_mode && g.ctrl[CTRL_USE_START]) ? SDIO_ST_ARMED
                                                                           : SDIO_ST_RUN;
        SDIO_ST_ARMED: if (start_ev) st <= SDIO_ST_RUN;
        SDIO_ST_RUN:   if (stop_ev) st <= SDIO_ST_IDLE;
        default:       st <= SDIO_ST_IDLE;
      endcase
    end
  end
  // Data capture, ack strobe and clock
  always_ff @(posedge clk) begin
    if (!resetn) begin
      last_in   <= 32'h0000_0000;
      g.data_in <= 32'h0000_0000;
      ack_d     <= 1'b0;
      g.pclk_out <= 1'b0;
      g.status  <= 8'h00;
    end else begin
      last_in <= g.pins_in;
      if (st == SDIO_ST_RUN && req_pulse) begin
        g.data_in <= g.pins_in;
        g.status[2] <= 1'b1;
      end else if (g.go) begin
        g.status[2] <= 1'b0;
      end
      ack_d <= (st == SDIO_ST_RUN) && !(req_pulse && mode == SDIO_MODE_HANDSHAKE);
      g.pclk_out <= (mode == SDIO_MODE_BURST) && (st == SDIO_ST_RUN) && !g.pclk_out;
      g.status[1:0] <= st;
      g.status[3] <= fire;
    end
  end
  assign g.ack_out = ack_d;
  assign g.drive   = (g.ctrl[CTRL_DIR_OUT] && st == SDIO_ST_RUN) ? owned : 32'h0000_0000;
endmodule // sdio_group

// File: verif/sdio_props.sv
// Checker of the strobed digital I/O block ports
`timescale 1ns/10ps
module sdio_props (
  input wire logic        clk,
  input wire logic        resetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [31:0] io_in,
  input wire logic [31:0] io_out,
  input wire logic [31:0] io_oe,
  input wire logic [1:0]  req_line,
  input wire logic [1:0]  stop_trigger_line,
  input wire logic [1:0]  start_trigger_line,
  input wire logic [1:0]  pclk_line
);
  // ----------------------------------------------------------------
  // Bus and reset properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  chk_ready_next: assert property (psel && !penable |=> pready)
    else $error("no ready after setup");
  chk_ready_access: assert property (pready |-> psel && penable)
    else $error("ready outside access");
  chk_ready_once: assert property (pready |=> !pready)
    else $error("ready held too long");
  chk_err_paired: assert property (pslverr |-> pready)
    else $error("error without ready");
  chk_unmapped_err: assert property (psel && !penable && paddr >= 8'h50 |=> pslverr)
    else $error("unmapped address accepted");
  chk_mapped_ok: assert property (psel && !penable && paddr < 8'h10 &&
    paddr[1:0] == 2'h0 |=> !pslverr)
    else $error("port register refused");
  chk_unmapped_zero: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0)
    else $error("unmapped read not zero");
  chk_rdata_hold: assert property (!(psel && !penable && !pwrite) |=> $stable(prdata))
    else $error("read data moved");
  // Reset is the cause here, so this one must not be disabled by it
  chk_reset_quiet: assert property (@(posedge clk) disable iff (1'b0)
    !resetn |=> io_oe == 32'h0 && io_out == 32'h0 && start_trigger_line == 2'h0)
    else $error("outputs active in reset");
  cover property (pready && pwrite);
  cover property (pready && pslverr);
  cover property ($rose(start_trigger_line[0]));
  cover property ($rose(pclk_line[1]));
endmodule // sdio_props
bind sdio_top sdio_props i_sdio_props (.clk(clk), .resetn(resetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .io_in(io_in), .io_out(io_out), .io_oe(io_oe),
  .req_line(req_line), .stop_trigger_line(stop_trigger_line),
  .start_trigger_line(start_trigger_line), .pclk_line(pclk_line));

// File: verif/sdio_periph.sv
// Peripheral model on the far side of the data and timing lines
`timescale 1ns/10ps
module sdio_periph (
  input  wire logic        clk,
  input  wire logic [31:0] io_out,
  input  wire logic [31:0] io_oe,
  input  wire logic [1:0]  start_trigger_line,
  input  wire logic [31:0] ext_data,
  input  wire logic        hold,
  input  wire logic        pace,
  input  wire logic [1:0]  stop_lvl,
  output logic [31:0]      io_in,
  output logic [1:0]       req_line,
  output logic [1:0]       stop_trigger_line
);
  // ----------------------------------------------------------------
  // Wire levels and strobes
  // ----------------------------------------------------------------
  logic [3:0] pace_cnt = 4'h0;
  logic [1:0] req_q    = 2'h0;
  // Each line shows whichever side drives it
  assign io_in = (io_out & io_oe) | (ext_data & ~io_oe);
  assign stop_trigger_line = stop_lvl;
  assign req_line = req_q;
  always_ff @(posedge clk) begin
    pace_cnt <= pace_cnt + 4'h1;
    // Answer the device strobe, unless told to hold back
    req_q[0] <= start_trigger_line[0] & ~hold;
    // External pacing: one pulse every sixteen cycles
    req_q[1] <= pace & (pace_cnt == 4'hF);
  end
endmodule // sdio_periph

// File: verif/tb_top.sv
// Testbench of the strobed digital I/O block
`timescale 1ns/10ps
module tb_top;
  import sdio_pkg::*;
  // ----------------------------------------------------------------
  // Signals, tasks and tests
  // ----------------------------------------------------------------
  logic        clk = 1'b0, resetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, ext = 32'h0, prdata, io_in, io_out, io_oe, r;
  logic [1:0]  stop_lvl = 2'h0, req_line, stop_trigger_line, start_trigger_line, pclk_line;
  logic        hold = 1'b1, pace = 1'b0, pready, pslverr, e;
  int          mismatches = 0, cmp_count = 0, i;
  always #4 clk = ~clk;
  sdio_top i_sdio_top (.clk(clk), .resetn(resetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .io_in(io_in), .io_out(io_out), .io_oe(io_oe), .req_line(req_line),
    .stop_trigger_line(stop_trigger_line), .start_trigger_line(start_trigger_line),
    .pclk_line(pclk_line));
  sdio_periph i_sdio_periph (.clk(clk), .io_out(io_out), .io_oe(io_oe),
    .start_trigger_line(start_trigger_line), .ext_data(ext), .hold(hold), .pace(pace),
    .stop_lvl(stop_lvl), .io_in(io_in), .req_line(req_line),
    .stop_trigger_line(stop_trigger_line));
  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // Request held until ready is sampled high; only the watchdog ends a hung wait
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rdc(input string s, input logic [7:0] a, input logic [31:0] m,
                     input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    chk(s, r & m, x);
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge clk);
  endtask
  function automatic logic [7:0] ga(input int g, input logic [7:0] off);
    return 8'(int'(OFF_G_BASE) + int'(G_STRIDE) * g + int'(off));
  endfunction
  function automatic logic [31:0] b(input int k);
    return 32'h1 << k;
  endfunction
  // Control word: enable, mode, owned ports, go, plus extra fields
  function automatic logic [31:0] cw(input logic [1:0] m, input logic [31:0] p,
                                     input logic [31:0] x);
    return b(CTRL_ENABLE) | (32'(m) << CTRL_MODE_LO) | p | b(CTRL_GO) | x;
  endfunction
  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    end_sim();
  end
  initial begin
    repeat (8) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    rdc("period reset", ga(0, OFF_G_PERIOD), 32'hFFFF_FFFF, PERIOD_RESET);
    rdc("ctrl reset", ga(1, OFF_G_CTRL), 32'hFFFF_FFFF, CTRL_RESET);
    wr(8'h60, 32'hFFFF_FFFF);
    rdc("unmapped", 8'h60, 32'hFFFF_FFFF, 32'h0);
    chk("slverr", {31'h0, e}, 32'h1);
    $display("test registers done");
    ext <= 32'h1234_5678;
    wr(OFF_PORT_DIR, 32'hFF00_FF00);
    wr(OFF_PORT_OUT, 32'hA5A5_5A5A);
    idle(4);
    chk("io_oe", io_oe, 32'hFF00_FF00);
    chk("io_out", io_out & io_oe, 32'hA500_5A00);
    rdc("pins", OFF_PORT_IN, 32'hFFFF_FFFF, 32'hA534_5A78);
    wr(OFF_PORT_DIR, 32'h0);
    wr(OFF_MISC, 32'h9);
    idle(3);
    chk("spare out", {28'h0, pclk_line, start_trigger_line}, 32'h9);
    stop_lvl <= 2'b10;
    idle(4);
    rdc("spare in", OFF_MISC, 32'h30, 32'h20);
    wr(OFF_MISC, 32'h0);
    $display("test unstrobed done");
    // Stop edge in pattern and handshake modes, both edge choices
    for (i = 0; i < 4; i++) begin
      stop_lvl <= {1'b0, ~i[0]};
      wr(ga(0, OFF_G_CTRL), cw(i[1] ? 2'b10 : 2'b00, b(CTRL_PORTS_LO),
         b(CTRL_USE_STOP) | (i[0] ? b(CTRL_STOP_RISE) : 32'h0)));
      idle(6);
      rdc("running", ga(0, OFF_G_STATUS), 32'h3, 32'h2);
      stop_lvl <= {1'b0, i[0]};
      idle(8);
      rdc("after stop", ga(0, OFF_G_STATUS), 32'h3, i[1] ? 32'h2 : 32'h0);
      wr(ga(0, OFF_G_CTRL), 32'h0);
    end
    $display("test triggers done");
    wr(ga(0, OFF_G_MASK), 32'hFF);
    wr(ga(0, OFF_G_PATTERN), 32'hAA);
    // Match then mismatch polarity; short blip first, then a held value
    for (i = 0; i < 2; i++) begin
      ext <= i[0] ? 32'hAA : 32'h00;
      wr(ga(0, OFF_G_CTRL), cw(2'b00, b(CTRL_PORTS_LO), b(CTRL_USE_START) | b(CTRL_PD_START)
         | (i[0] ? b(CTRL_PD_MISMATCH) : 32'h0)));
      idle(4);
      ext <= i[0] ? 32'h55 : 32'hAA;
      idle(2);
      ext <= i[0] ? 32'hAA : 32'h00;
      idle(10);
      rdc("glitch", ga(0, OFF_G_STATUS), 32'h3, 32'h1);
      ext <= i[0] ? 32'h55 : 32'hAA;
      idle(8);
      rdc("detect", ga(0, OFF_G_STATUS), 32'h3, 32'h2);
      wr(ga(0, OFF_G_CTRL), 32'h0);
    end
    $display("test pattern detect done");
    ext <= 32'h0;
    wr(ga(0, OFF_G_MASK), 32'h01);
    wr(ga(0, OFF_G_CTRL), cw(2'b01, b(CTRL_PORTS_LO), 32'h0));
    idle(6);
    ext <= 32'h10;
    idle(8);
    rdc("no change", ga(0, OFF_G_STATUS), 32'h4, 32'h0);
    ext <= 32'h11;
    idle(8);
    rdc("change data", ga(0, OFF_G_DATA_IN), 32'hFF, 32'h11);
    wr(ga(0, OFF_G_CTRL), 32'h0);
    $display("test change detect done");
    // Handshake on group 0 beside externally paced group 1
    ext <= 32'h3C;
    wr(ga(0, OFF_G_CTRL), cw(2'b10, b(CTRL_PORTS_LO), 32'h0));
    wr(ga(1, OFF_G_CTRL), cw(2'b00, b(CTRL_PORTS_LO + 1), b(CTRL_EXT_REQ)));
    idle(20);
    rdc("held", ga(0, OFF_G_STATUS), 32'h4, 32'h0);
    rdc("unpaced", ga(1, OFF_G_STATUS), 32'h4, 32'h0);
    hold <= 1'b0;
    pace <= 1'b1;
    idle(40);
    rdc("hs data", ga(0, OFF_G_DATA_IN), 32'hFF, 32'h3C);
    rdc("paced", ga(1, OFF_G_STATUS), 32'h4, 32'h4);
    // Burst output on group 1: its port carries the data-out word, its clock toggles
    wr(ga(1, OFF_G_DATA_OUT), 32'h0000_C300);
    wr(ga(1, OFF_G_CTRL), cw(2'b11, b(CTRL_PORTS_LO + 1), b(CTRL_DIR_OUT)));
    idle(3);
    chk("grp oe", io_oe, 32'h0000_FF00);
    chk("grp out", io_out & io_oe, 32'h0000_C300);
    @(negedge clk);
    e = pclk_line[1];
    @(negedge clk);
    chk("pclk", {31'h0, pclk_line[1]}, {31'h0, ~e});
    $display("test handshake done");
    end_sim();
  end
endmodule // tb_top
